// [hdl/spr_defines.svh]
// Offsets, field positions, reset values and timing for the shared pin block.
`ifndef SPR_DEFINES_SVH
`define SPR_DEFINES_SVH
`define SPR_OFF_SYSCTL      8'h00
`define SPR_OFF_FUNC        8'h04
`define SPR_OFF_DIR         8'h08
`define SPR_OFF_DOUT        8'h0C
`define SPR_OFF_DIN         8'h10
`define SPR_OFF_ACTION      8'h14
`define SPR_OFF_PROT        8'h18
`define SPR_OFF_FLAG        8'h1C
`define SPR_OFF_MULT        8'h20
`define SPR_OFF_CORE        8'h24
`define SPR_PIN_FLAG        3
`define SPR_PIN_BRANCH      4
`define SPR_PIN_CLOCK_OUT_PIN      5
`define SPR_FUNC_POR_RST    12'h038
`define SPR_FUNC_WARM_RST   12'h018
`define SPR_FUNC_KEEP_MASK  12'h020
`define SPR_OE_RST          12'h008
`define SPR_OE_CLOCK_OUT_PIN       12'h020
`define SPR_OE_FIXED_IN     12'h017
`define SPR_PROT_UNMASK     0
`define SPR_PROT_CMPEN      1
`define SPR_PROT_TRIP       2
`define SPR_CMP_ALL         6'h3F
`define SPR_MULT_RST        4'h0
`define SPR_CLK_NS          8
`define SPR_STABLE_NS       1000
`endif

// [hdl/spr_pkg.sv]
// Types shared by the shared pin block and its pin cells.
package spr_pkg;
    // Action control encoding for each full-compare output.
    typedef enum logic [1:0] {
        spr_act_force_lo,
        spr_act_low,
        spr_act_high,
        spr_act_force_hi
    } spr_act_t;

    // Level and output enable of one pin driver.
    typedef struct packed {
        logic o;
        logic oe;
    } spr_drive_t;
endpackage : spr_pkg

// [hdl/spr_sync2.sv]
// Two flip-flop synchroniser for inputs that come from pins.
module spr_sync2 #(
    parameter int W = 1
) (
    input  wire logic         ref_clk,
    input  wire logic         rst_b,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_reg;

    // The first stage feeds only the second, so metastability settles there.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q        <= '0;
        end else begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : spr_sync2

// [hdl/spr_pin_cell.sv]
// Driver selection for one shared pin: peripheral function or general I/O.
module spr_pin_cell (
    input  wire logic               func_sel,
    input  wire logic               fn_o,
    input  wire logic               fn_oe,
    input  wire logic               dir,
    input  wire logic               dout,
    output spr_pkg::spr_drive_t     drv
);
    // An input-only setting leaves the driver off; the level is still read.
    always_comb begin
        if (func_sel) begin
            drv.o  = fn_o;
            drv.oe = fn_oe;
        end else begin
            drv.o  = dout;
            drv.oe = dir;
        end
    end
endmodule : spr_pin_cell

// [hdl/spr_pin_mux.sv]
// Shared pin logic with reset defaults, compare drivers and APB registers.
//
// Overview of operation
// - Capture pin 2 is capture, encoder or I/O; every reset makes it input.
// - Capture pins 3 and 4 are capture or I/O; every reset makes them input.
// - Flag pin drives a latched software flag; every reset selects that.
// - Branch pin low makes the branch taken; every reset selects it.
// - Clock source select field of system control picks the clock output.
// - Only power-on reset selects clock output; the reset pin keeps its selection.
// - Async transmit pin is transmit data or I/O; reset makes it input.
// - Async receive pin is receive data or I/O; reset makes it input.
// - Sync data-out, data-in and clock pins reset to digital inputs.
// - Sync select pin is transmit enable or I/O; reset makes it input.
// - Each compare output follows compare level qualified by action control.
// - Unmasked protect input low puts all six compare outputs in high-Z.
// - After power-on the compare outputs stay high-Z until clock is stable.
// - Reset stops execution, clears program counter; release resumes at zero.
// - Reset sets internal registers and status bits to defined values.
// - Unmasked protect input low puts compare outputs in high-Z at once; the logic does so on the third ref_clk edge after the pin falls.
// - Power-on reset also initialises the clock multiplier control.
`include "spr_defines.svh"
module spr_pin_mux (
    input  wire logic        ref_clk,
    input  wire logic        rst_b,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [11:0] pin_i,
    output logic      [11:0] pin_o,
    output logic      [11:0] pin_oe,
    input  wire logic [11:0] periph_o,
    input  wire logic [11:0] periph_oe,
    output logic      [11:0] periph_i,
    input  wire logic [5:0]  cmp_level,
    output logic      [5:0]  full_compare_out_o,
    output logic      [5:0]  full_compare_out_oe,
    input  wire logic        power_drive_protect_in_b,
    input  wire logic        reset_in_pin_b,
    input  wire logic        power_on_reset_in_b,
    input  wire logic        core_step,
    input  wire logic        core_branch_query,
    output logic      [15:0] core_pc,
    output logic             core_run,
    output logic             branch_taken,
    output logic      [3:0]  clk_mult
);
    localparam int STABLE_CYCLES =
        (`SPR_STABLE_NS + `SPR_CLK_NS - 1) / `SPR_CLK_NS;
    localparam int CNT_W = $clog2(STABLE_CYCLES + 1);

    logic [14:0]      sync_q;
    logic [11:0]      pin_sync;
    logic             pdp_b_s;
    logic             por_rst;
    logic             any_rst;
    logic             wr_en;
    logic             addr_ok;
    logic [31:0]      rd_mux;
    logic             pready_reg;
    logic [31:0]      prdata_reg;
    logic             pslverr_reg;
    logic [1:0]       clk_src_reg;
    logic [11:0]      func_sel_reg;
    logic [11:0]      dir_reg;
    logic [11:0]      dout_reg;
    logic [11:0]      action_reg;
    logic             unmask_reg;
    logic             cmpen_reg;
    logic             trip_reg;
    logic             flag_reg;
    logic [3:0]       clk_mult_reg;
    logic [CNT_W-1:0] stable_cnt_reg;
    logic             stable_reg;
    logic [2:0]       div_reg;
    logic             clock_out_pin_reg;
    logic [15:0]      core_pc_reg;
    logic             core_run_reg;
    logic             branch_taken_reg;
    logic [11:0]      fn_o;
    logic [11:0]      fn_oe;
    logic [11:0]      pin_o_next;
    logic [11:0]      pin_oe_next;
    logic [11:0]      pin_o_reg;
    logic [11:0]      pin_oe_reg;
    logic [5:0]       cmp_o_next;
    logic [5:0]       cmp_o_reg;
    logic [5:0]       cmp_oe_reg;

    // Pins, protect input and both reset pins are asynchronous to ref_clk.
    spr_sync2 #(
        .W(15)
    ) u_sync (
        .ref_clk(ref_clk),
        .rst_b  (rst_b),
        .d      ({power_on_reset_in_b, reset_in_pin_b,
                  power_drive_protect_in_b, pin_i}),
        .q      (sync_q)
    );

    // The synchroniser clears to zero, so resets hold two edges past rst_b.
    assign pin_sync = sync_q[11:0];
    assign pdp_b_s  = sync_q[12];
    assign por_rst  = !rst_b || !sync_q[14];
    assign any_rst  = por_rst || !sync_q[13];

    // One wait state: pready rises in the second access cycle.
    assign wr_en = psel && penable && pready_reg && pwrite && !any_rst;

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= psel && penable && !pready_reg;
            prdata_reg  <= (psel && penable && !pready_reg && !pwrite) ?
                           rd_mux : 32'h0000_0000;
            pslverr_reg <= psel && penable && !pready_reg && !addr_ok;
        end
    end

    // Read decode; unmapped addresses return zero with an error answer.
    always_comb begin
        addr_ok = 1'b1;
        unique case (paddr)
            `SPR_OFF_SYSCTL: rd_mux = 32'(clk_src_reg);
            `SPR_OFF_FUNC:   rd_mux = 32'(func_sel_reg);
            `SPR_OFF_DIR:    rd_mux = 32'(dir_reg);
            `SPR_OFF_DOUT:   rd_mux = 32'(dout_reg);
            `SPR_OFF_DIN:    rd_mux = 32'(pin_sync);
            `SPR_OFF_ACTION: rd_mux = 32'(action_reg);
            `SPR_OFF_PROT:   rd_mux = 32'({pdp_b_s, stable_reg, trip_reg,
                                           cmpen_reg, unmask_reg});
            `SPR_OFF_FLAG:   rd_mux = 32'(flag_reg);
            `SPR_OFF_MULT:   rd_mux = 32'(clk_mult_reg);
            `SPR_OFF_CORE:   rd_mux = 32'({core_run_reg, core_pc_reg});
            default: begin
                rd_mux  = 32'h0000_0000;
                addr_ok = 1'b0;
            end
        endcase
    end

    // System control: clock source select, cleared by every reset.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            clk_src_reg <= 2'h0;
        end else if (wr_en && paddr == `SPR_OFF_SYSCTL) begin
            clk_src_reg <= pwdata[1:0];
        end
    end

    // Function select; only power-on reset selects the clock output.
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            func_sel_reg <= `SPR_FUNC_POR_RST;
        end else if (any_rst) begin
            func_sel_reg <= `SPR_FUNC_WARM_RST |
                            (func_sel_reg & `SPR_FUNC_KEEP_MASK);
        end else if (wr_en && paddr == `SPR_OFF_FUNC) begin
            func_sel_reg <= pwdata[11:0];
        end
    end

    // General I/O direction and data; reset clears every direction bit to input.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            dir_reg  <= 12'h000;
            dout_reg <= 12'h000;
        end else if (wr_en && paddr == `SPR_OFF_DIR) begin
            dir_reg <= pwdata[11:0];
        end else if (wr_en && paddr == `SPR_OFF_DOUT) begin
            dout_reg <= pwdata[11:0];
        end
    end

    // Action control, latched flag and compare enable.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            action_reg <= 12'h000;
            flag_reg   <= 1'b0;
            unmask_reg <= 1'b0;
            cmpen_reg  <= 1'b0;
        end else if (wr_en && paddr == `SPR_OFF_ACTION) begin
            action_reg <= pwdata[11:0];
        end else if (wr_en && paddr == `SPR_OFF_FLAG) begin
            flag_reg <= pwdata[0];
        end else if (wr_en && paddr == `SPR_OFF_PROT) begin
            unmask_reg <= pwdata[`SPR_PROT_UNMASK];
            cmpen_reg  <= pwdata[`SPR_PROT_CMPEN];
        end
    end

    // Trip flag: an unmasked low protect level wins over a software clear.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            trip_reg <= 1'b0;
        end else if (unmask_reg && !pdp_b_s) begin
            trip_reg <= 1'b1;
        end else if (wr_en && paddr == `SPR_OFF_PROT &&
                     pwdata[`SPR_PROT_TRIP]) begin
            trip_reg <= 1'b0;
        end
    end

    // Clock multiplier control survives the reset pin, not power-on reset.
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            clk_mult_reg <= `SPR_MULT_RST;
        end else if (wr_en && paddr == `SPR_OFF_MULT) begin
            clk_mult_reg <= pwdata[3:0];
        end
    end

    // Clock settling timer restarted by power-on reset only.
    always_ff @(posedge ref_clk) begin
        if (por_rst) begin
            stable_cnt_reg <= '0;
            stable_reg     <= 1'b0;
        end else if (!stable_reg) begin
            stable_cnt_reg <= stable_cnt_reg + CNT_W'(1);
            stable_reg     <= stable_cnt_reg == CNT_W'(STABLE_CYCLES - 1);
        end
    end

    // Divider taps give the clock output; select values 0 to 2 pick a tap, 3 holds it low.
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            div_reg    <= 3'h0;
            clock_out_pin_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 3'h1;
            unique case (clk_src_reg)
                2'h0: clock_out_pin_reg <= div_reg[0];
                2'h1: clock_out_pin_reg <= div_reg[1];
                2'h2: clock_out_pin_reg <= div_reg[2];
                2'h3: clock_out_pin_reg <= 1'b0;
            endcase
        end
    end

    // Core execution state: reset stops it and clears the counter.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            core_pc_reg  <= 16'h0000;
            core_run_reg <= 1'b0;
        end else begin
            core_run_reg <= 1'b1;
            if (core_step && core_run_reg) begin
                core_pc_reg <= core_pc_reg + 16'h0001;
            end
        end
    end

    // Branch decision taken from the sampled branch pin; low means branch.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            branch_taken_reg <= 1'b0;
        end else begin
            branch_taken_reg <= core_branch_query &&
                                func_sel_reg[`SPR_PIN_BRANCH] &&
                                !pin_sync[`SPR_PIN_BRANCH];
        end
    end

    // Function-side drive: flag and clock drive; input functions never do.
    always_comb begin
        fn_o  = periph_o;
        fn_oe = periph_oe & ~`SPR_OE_FIXED_IN;
        fn_o[`SPR_PIN_FLAG] = flag_reg;
        fn_oe[`SPR_PIN_FLAG] = 1'b1;
        fn_o[`SPR_PIN_CLOCK_OUT_PIN] = clock_out_pin_reg;
        fn_oe[`SPR_PIN_CLOCK_OUT_PIN] = 1'b1;
    end

    // One driver cell per shared pin.
    for (genvar i = 0; i < 12; i++) begin : g_pin
        spr_pkg::spr_drive_t drv;

        spr_pin_cell u_cell (
            .func_sel(func_sel_reg[i]),
            .fn_o    (fn_o[i]),
            .fn_oe   (fn_oe[i]),
            .dir     (dir_reg[i]),
            .dout    (dout_reg[i]),
            .drv     (drv)
        );
        assign pin_o_next[i]  = drv.o;
        assign pin_oe_next[i] = drv.oe;
    end

    // Pin outputs are registered so glitches never reach the pads.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            pin_o_reg  <= 12'h000;
            pin_oe_reg <= `SPR_OE_RST |
                          ((por_rst || func_sel_reg[`SPR_PIN_CLOCK_OUT_PIN]) ?
                           `SPR_OE_CLOCK_OUT_PIN : 12'h000);
        end else begin
            pin_o_reg  <= pin_o_next;
            pin_oe_reg <= pin_oe_next;
        end
    end

    // Compare level per output as qualified by its action field.
    for (genvar i = 0; i < 6; i++) begin : g_cmp
        spr_pkg::spr_act_t act;
        logic              lvl;

        assign act = spr_pkg::spr_act_t'(action_reg[2*i +: 2]);
        // Each output has its own process, so one driver per vector bit.
        always_comb begin
            unique case (act)
                spr_pkg::spr_act_force_lo: lvl = 1'b0;
                spr_pkg::spr_act_low:      lvl = !cmp_level[i];
                spr_pkg::spr_act_high:     lvl = cmp_level[i];
                spr_pkg::spr_act_force_hi: lvl = 1'b1;
            endcase
        end
        assign cmp_o_next[i] = lvl;
    end

    // High-Z until the clock settles and software enables; a trip overrides.
    always_ff @(posedge ref_clk) begin
        if (any_rst) begin
            cmp_o_reg  <= 6'h00;
            cmp_oe_reg <= 6'h00;
        end else begin
            cmp_o_reg  <= cmp_o_next;
            cmp_oe_reg <= (stable_reg && cmpen_reg && !trip_reg &&
                           !(unmask_reg && !pdp_b_s)) ?
                          `SPR_CMP_ALL : 6'h00;
        end
    end

    assign prdata              = prdata_reg;
    assign pready              = pready_reg;
    assign pslverr             = pslverr_reg;
    assign pin_o               = pin_o_reg;
    assign pin_oe              = pin_oe_reg;
    assign periph_i            = pin_sync;
    assign full_compare_out_o  = cmp_o_reg;
    assign full_compare_out_oe = cmp_oe_reg;
    assign core_pc             = core_pc_reg;
    assign core_run            = core_run_reg;
    assign branch_taken        = branch_taken_reg;
    assign clk_mult            = clk_mult_reg;

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    capture_in_2_reset_input_a: assert property (
        any_rst |=> !pin_oe_reg[0] && !func_sel_reg[0] && !dir_reg[0])
        else $error("capture pin 2 not an input after reset");
    cap34_reset_input_a: assert property (
        any_rst |=> pin_oe_reg[2:1] == 2'h0 ##1 !$rose(pin_oe_reg[1]))
        else $error("capture pins 3 or 4 driven after reset");
    flag_reset_drive_a: assert property (
        any_rst ##1 !any_rst |-> pin_oe_reg[3] ##1 pin_oe_reg[3])
        else $error("flag pin not driven after reset");
    branch_low_take_a: assert property (
        core_branch_query && func_sel_reg[4] && !pin_sync[4] && !any_rst
        |=> branch_taken_reg)
        else $error("low branch pin did not take branch");
    clock_out_pin_por_only_a: assert property (
        any_rst && !por_rst |=> func_sel_reg[5] == $past(func_sel_reg[5]))
        else $error("reset pin changed clock output selection");
    serial_reset_input_a: assert property (
        any_rst |=> pin_oe_reg[11:6] == 6'h00 && dir_reg[11:6] == 6'h00)
        else $error("serial pin driven after reset");
    cmp_trip_hiz_a: assert property (
        unmask_reg && !pdp_b_s && !any_rst
        |=> cmp_oe_reg == 6'h00 && trip_reg)
        else $error("compare outputs not high-Z on protect");
    cmp_trip_hold_a: assert property (
        trip_reg && !any_rst |=> cmp_oe_reg == 6'h00)
        else $error("compare driven while tripped");
    cmp_unstable_hiz_a: assert property (
        !stable_reg |=> cmp_oe_reg == 6'h00)
        else $error("compare driven before clock stable");
    cmp_active_high_a: assert property (
        action_reg[1:0] == 2'h2 && !any_rst
        |=> cmp_o_reg[0] == $past(cmp_level[0]))
        else $error("compare 1 level not following compare logic");
    pc_reset_zero_a: assert property (
        any_rst |=> core_pc_reg == 16'h0000 && !core_run_reg)
        else $error("program counter not cleared by reset");
    mult_por_init_a: assert property (
        por_rst |=> clk_mult_reg == `SPR_MULT_RST)
        else $error("multiplier control not initialised");

    trip_seen_c: cover property (unmask_reg && !pdp_b_s ##1 trip_reg);
    warm_reset_c: cover property (any_rst && !por_rst ##1 !any_rst);
    cmp_drive_c: cover property (cmp_oe_reg == `SPR_CMP_ALL);
endmodule : spr_pin_mux

// [test/spr_board.sv]
// Board model for the shared pads: drivers, pads and external levels.
module spr_board (
    input  wire logic [11:0] pin_o,
    input  wire logic [11:0] pin_oe,
    input  wire logic [11:0] board_lvl,
    output logic      [11:0] pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pad that the device does not drive shows the board's level.
    always_comb begin
        for (int i = 0; i < 12; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : board_lvl[i];
        end
    end
endmodule : spr_board

// [test/tb_shared_pin_reset_defaults.sv]
// Self-checking bench for the shared pin block.
module tb_shared_pin_reset_defaults;
    timeunit 1ns;
    timeprecision 1ps;
    logic        ref_clk = 1'b0;
    logic        rst_b = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [11:0] pin_i;
    logic [11:0] pin_o;
    logic [11:0] pin_oe;
    logic [11:0] board_lvl = 12'hFFF;
    logic [11:0] periph_i;
    logic [5:0]  cmp_level = 6'h00;
    logic [5:0]  cmp_o;
    logic [5:0]  cmp_oe;
    logic        prot_b = 1'b1;
    logic        warm_b = 1'b1;
    logic        query = 1'b0;
    logic        por_b = 1'b1;
    logic        step = 1'b0;
    logic        ck;
    logic [15:0] core_pc;
    logic        core_run;
    logic        branch_taken;
    logic [3:0]  clk_mult;
    logic [31:0] rd;
    logic        er;
    logic [31:0] act;
    int          err_count = 0;
    int          compares = 0;
    int          seed = 32'hdc4e16f7;
    spr_pin_mux dut (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_i(pin_i),
        .pin_o(pin_o), .pin_oe(pin_oe), .periph_o(12'h000),
        .periph_oe(12'h000), .periph_i(periph_i), .cmp_level(cmp_level),
        .full_compare_out_o(cmp_o), .full_compare_out_oe(cmp_oe),
        .power_drive_protect_in_b(prot_b), .reset_in_pin_b(warm_b),
        .power_on_reset_in_b(por_b), .core_step(step),
        .core_branch_query(query), .core_pc(core_pc), .core_run(core_run),
        .branch_taken(branch_taken), .clk_mult(clk_mult));
    spr_board board (.pin_o(pin_o), .pin_oe(pin_oe), .board_lvl(board_lvl),
        .pin_i(pin_i));
    // Free-running core clock, 8 ns period.
    always #4 ref_clk = ~ref_clk;
    // Prints the verdict once and ends the run.
    task automatic print_verdict();
        if (err_count == 0 && compares > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : print_verdict
    // Compares one value and counts a mismatch.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; waits for pready under a bound.
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            err_count++;
            print_verdict();
        end
    endtask : apb
    // Expected compare pin level for one action code.
    function automatic logic act_out(input logic [1:0] a, input logic l);
        case (a)
            2'd0: return 1'b0;
            2'd1: return ~l;
            2'd2: return l;
            default: return 1'b1;
        endcase
    endfunction : act_out
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : cyc
    // Main sequence: reset defaults, branch, compare, protect, I/O, warm reset.
    initial begin
        cyc(3);
        rst_b <= 1'b1;
        cyc(4);
        chk(pin_oe, 32'h028);
        chk({pin_o[11:6], pin_o[4:0], cmp_oe, clk_mult}, 0);
        // The clock output pin toggles every cycle with the default source.
        ck = pin_o[5];
        cyc(1);
        chk(pin_o[5], !ck);
        apb(1'b0, 8'h04, 0);
        chk(rd, 32'h038);
        apb(1'b0, 8'h3C, 0);
        chk(er, 1);
        // Branch pin sampled low means taken, high means not taken.
        for (int v = 0; v < 2; v++) begin
            board_lvl[4] <= v[0];
            cyc(4);
            query <= 1'b1;
            cyc(1);
            query <= 1'b0;
            chk(branch_taken, !v[0]);
        end
        cyc(120);
        apb(1'b1, 8'h18, 32'h3);
        // Random action codes and compare levels.
        for (int k = 0; k < 4; k++) begin
            act = $random(seed);
            cmp_level <= $random(seed);
            apb(1'b1, 8'h14, {20'h0, act[11:0]});
            cyc(2);
            for (int i = 0; i < 6; i++)
                chk(cmp_o[i], act_out(act[2*i+:2], cmp_level[i]));
            chk(cmp_oe, 6'h3F);
        end
        prot_b <= 1'b0;
        cyc(4);
        chk(cmp_oe, 0);
        prot_b <= 1'b1;
        cyc(4);
        chk(cmp_oe, 0);
        apb(1'b1, 8'h18, 32'h7);
        cyc(2);
        chk(cmp_oe, 6'h3F);
        apb(1'b1, 8'h04, 0);
        act = $random(seed);
        apb(1'b1, 8'h08, act);
        cyc(2);
        chk(pin_oe, act[11:0]);
        apb(1'b1, 8'h08, 0);
        board_lvl <= act[23:12];
        cyc(3);
        apb(1'b0, 8'h10, 0);
        chk(rd, act[23:12]);
        apb(1'b1, 8'h20, 32'h5);
        warm_b <= 1'b0;
        cyc(4);
        chk(pin_oe, 32'h008);
        chk({core_run, core_pc, cmp_oe}, 0);
        chk(clk_mult, 4'h5);
        warm_b <= 1'b1;
        cyc(4);
        apb(1'b0, 8'h04, 0);
        chk(rd, 32'h018);
        // Execution resumes from zero and advances once per step.
        step <= 1'b1;
        cyc(3);
        step <= 1'b0;
        chk({core_run, core_pc}, {1'b1, 16'h0003});
        // Power-on reset restores clock output and multiplier control.
        por_b <= 1'b0;
        cyc(4);
        chk(pin_oe, 32'h028);
        chk({clk_mult, core_pc, cmp_oe}, 0);
        por_b <= 1'b1;
        cyc(4);
        print_verdict();
    end
endmodule : tb_shared_pin_reset_defaults
